// ---- src/adcsp_top.sv ----
/*
  Shared-pin logic of a sampling converter: parallel upper data bits, serial
  frame strobe, incomplete-read flag, serial configuration port, busy and a
  small register port with interrupt.
  Assumes pins and straps are asynchronous to clk; conv_data comes from the
  converter core on clk and is stable when a conversion ends.
*/
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "adcsp_map.svh"

module adcsp_top import adcsp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Shared pins, index 0 is bit eight
  input wire logic [4:0] shared_in,
  output logic [4:0] shared_out,
  output logic [4:0] shared_oe,
  // Mode straps
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic frame_polarity_select,
  input wire logic clock_edge_invert,
  // Configuration port and hardware config
  input wire logic config_port_select_n,
  input wire logic [1:0] hw_range,
  input wire logic [1:0] hw_mode,
  // Serial data
  input wire logic sdclk_in,
  output logic sdclk_out,
  output logic sdclk_oe,
  output logic serial_result_out,
  // Converter
  input wire logic conv_start_n,
  input wire logic [13:0] conv_data,
  output logic busy,
  output logic [1:0] cfg_range,
  output logic [1:0] cfg_mode,
  // Interrupt
  output logic irq
);

  localparam logic [7:0] CONV_LAST = 8'(`ADCSP_CONV_CYC - 1);
  localparam logic [2:0] HALF_LAST = 3'(`ADCSP_SCLK_HALF - 1);
  localparam logic [3:0] BIT_LAST = 4'(`ADCSP_RES_W - 1);
  localparam logic [3:0] CFG_FULL = 4'(`ADCSP_CFG_BITS);

  // Two-stage input synchroniser
  logic [15:0] pin_raw;
  logic [15:0] sy1_r;
  logic [15:0] sy2_r;
  assign pin_raw = {hw_mode, hw_range, clock_edge_invert, frame_polarity_select,
                    clock_source_select, serial_parallel_select, conv_start_n,
                    sdclk_in, config_port_select_n, shared_in};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Idle levels of start and select pins, so no false edge after reset
      sy1_r <= 16'h00A0;
      sy2_r <= 16'h00A0;
    end else begin
      sy1_r <= pin_raw;
      sy2_r <= sy1_r;
    end
  end

  logic [1:0] m_hw_mode;
  logic [1:0] m_hw_range;
  logic m_inv;
  logic m_pol;
  logic m_ext;
  logic m_ser;
  logic m_cst_n;
  logic m_sdclk;
  logic m_cs_n;
  logic [4:0] m_sh;
  assign {m_hw_mode, m_hw_range, m_inv, m_pol, m_ext, m_ser, m_cst_n,
          m_sdclk, m_cs_n, m_sh} = sy2_r;

  logic master;
  logic slave;
  logic cfg_hw;
  assign master = m_ser & ~m_ext;
  assign slave = m_ser & m_ext;
  assign cfg_hw = ~m_ser | m_sh[2];

  // Edge history
  logic cst_prev_r;
  logic sd_prev_r;
  logic cclk_prev_r;
  logic cs_prev_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cst_prev_r <= 1'b1;
      sd_prev_r <= 1'b0;
      cclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      cst_prev_r <= m_cst_n;
      sd_prev_r <= m_sdclk;
      cclk_prev_r <= m_sh[4];
      cs_prev_r <= m_cs_n;
    end
  end

  // Configuration port
  logic cfg_edge;
  logic cfg_take;
  logic cfg_end;
  logic [7:0] cfg_sh_r;
  logic [3:0] cfg_cnt_r;
  logic [7:0] cfg_word_r;
  logic cfg_ld_r;
  assign cfg_edge = m_inv ? (cclk_prev_r & ~m_sh[4]) : (~cclk_prev_r & m_sh[4]);
  assign cfg_take = m_ser & ~m_sh[2] & ~m_cs_n & cfg_edge;
  assign cfg_end = ~cs_prev_r & m_cs_n;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_sh_r <= 8'h00;
      cfg_cnt_r <= 4'h0;
      cfg_word_r <= 8'h00;
      cfg_ld_r <= 1'b0;
    end else begin
      cfg_ld_r <= 1'b0;
      if (cfg_take) begin
        cfg_sh_r <= {cfg_sh_r[6:0], m_sh[3]};
        if (cfg_cnt_r != CFG_FULL) begin
          cfg_cnt_r <= cfg_cnt_r + 4'h1;
        end
      end else if (cfg_end) begin
        cfg_cnt_r <= 4'h0;
        if (cfg_cnt_r == CFG_FULL && m_ser && !m_sh[2]) begin
          cfg_word_r <= cfg_sh_r;
          cfg_ld_r <= 1'b1;
        end
      end
    end
  end

  // Active configuration
  logic [1:0] cfg_range_r;
  logic [1:0] cfg_mode_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_range_r <= 2'h0;
      cfg_mode_r <= 2'h0;
    end else if (cfg_hw) begin
      cfg_range_r <= m_hw_range;
      cfg_mode_r <= m_hw_mode;
    end else begin
      cfg_range_r <= cfg_word_r[`ADCSP_CFG_RANGE_LSB +: 2];
      cfg_mode_r <= cfg_word_r[`ADCSP_CFG_MODE_LSB +: 2];
    end
  end

  // Conversion timing
  logic soft_start;
  logic start_evt;
  logic latch;
  logic busy_r;
  logic [7:0] conv_cnt_r;
  logic done_r;
  assign soft_start = reg_wr & (reg_addr == `ADCSP_ADDR_CTRL)
                      & reg_wdata[`ADCSP_CTRL_START];
  assign start_evt = (cst_prev_r & ~m_cst_n) | soft_start;
  assign latch = busy_r & ~done_r & (conv_cnt_r == CONV_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      conv_cnt_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= latch;
      if (!busy_r && start_evt) begin
        busy_r <= 1'b1;
        conv_cnt_r <= 8'h00;
      end else if (done_r) begin
        busy_r <= 1'b0;
      end else if (busy_r && !latch) begin
        conv_cnt_r <= conv_cnt_r + 8'h01;
      end
    end
  end

  // Serial engine
  adcsp_ser_t st_r;
  logic [13:0] sh_r;
  logic [13:0] result_r;
  logic [3:0] bit_r;
  logic [2:0] div_r;
  logic sclk_r;
  logic rdy_r;
  logic err_r;
  logic sd_edge;
  assign sd_edge = m_inv ? (sd_prev_r & ~m_sdclk) : (~sd_prev_r & m_sdclk);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= SER_IDLE;
      sh_r <= 14'h0000;
      result_r <= 14'h0000;
      bit_r <= 4'h0;
      div_r <= 3'h0;
      sclk_r <= 1'b0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      err_r <= 1'b0;
      case (st_r)
        SER_IDLE: begin
          sclk_r <= 1'b0;
          if (latch) begin
            result_r <= conv_data;
            sh_r <= conv_data;
            bit_r <= 4'h0;
            div_r <= 3'h0;
            rdy_r <= slave;
            if (master) begin
              st_r <= SER_MREAD;
            end
          end else if (slave && rdy_r && sd_edge) begin
            st_r <= SER_SREAD;
            sh_r <= {sh_r[12:0], 1'b0};
            bit_r <= 4'h1;
          end
        end
        SER_MREAD: begin
          if (!master) begin
            st_r <= SER_IDLE;
          end else if (div_r == HALF_LAST) begin
            div_r <= 3'h0;
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              sh_r <= {sh_r[12:0], 1'b0};
              bit_r <= bit_r + 4'h1;
              if (bit_r == BIT_LAST) begin
                st_r <= SER_IDLE;
              end
            end
          end else begin
            div_r <= div_r + 3'h1;
          end
        end
        SER_SREAD: begin
          if (latch) begin
            err_r <= 1'b1;
          end
          if (!slave) begin
            st_r <= SER_IDLE;
            rdy_r <= 1'b0;
          end else if (sd_edge) begin
            sh_r <= {sh_r[12:0], 1'b0};
            bit_r <= bit_r + 4'h1;
            if (bit_r == BIT_LAST) begin
              st_r <= SER_IDLE;
              rdy_r <= 1'b0;
            end
          end
        end
        default: begin
          st_r <= SER_IDLE;
        end
      endcase
    end
  end

  // Pin drivers
  logic [4:0] shared_out_r;
  logic [4:0] shared_oe_r;
  logic sdclk_out_r;
  logic sdclk_oe_r;
  logic sdo_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shared_out_r <= 5'h00;
      shared_oe_r <= 5'h00;
      sdclk_out_r <= 1'b0;
      sdclk_oe_r <= 1'b0;
      sdo_r <= 1'b0;
    end else if (!m_ser) begin
      shared_out_r <= result_r[12:8];
      shared_oe_r <= 5'h1F;
      sdclk_out_r <= 1'b0;
      sdclk_oe_r <= 1'b0;
      sdo_r <= 1'b0;
    end else begin
      shared_out_r <= {3'h0, err_r & slave,
                       ((st_r == SER_MREAD) ^ m_pol) & master};
      shared_oe_r <= {3'h0, slave, master};
      sdclk_out_r <= sclk_r & master;
      sdclk_oe_r <= master;
      sdo_r <= sh_r[13];
    end
  end

  // Interrupt status
  logic [2:0] st_set;
  logic [2:0] st_clr;
  logic [2:0] status_r;
  logic [2:0] irq_en_r;
  logic irq_r;
  assign st_set = {cfg_ld_r, err_r & slave, done_r};
  assign st_clr = (reg_wr && reg_addr == `ADCSP_ADDR_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= 3'h0;
      irq_en_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
      if (reg_wr && reg_addr == `ADCSP_ADDR_IRQ_EN) begin
        irq_en_r <= reg_wdata[2:0];
      end
      irq_r <= |(status_r & irq_en_r);
    end
  end

  // Register read
  logic [31:0] rdata_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADCSP_ADDR_CTRL: rdata_r <= {31'h0000_0000, busy_r};
        `ADCSP_ADDR_STATUS: rdata_r <= {29'h0000_0000, status_r};
        `ADCSP_ADDR_IRQ_EN: rdata_r <= {29'h0000_0000, irq_en_r};
        `ADCSP_ADDR_RESULT: rdata_r <= {18'h0_0000, result_r};
        `ADCSP_ADDR_CONFIG: begin
          rdata_r <= {19'h0_0000, cfg_hw, cfg_word_r, cfg_mode_r, cfg_range_r};
        end
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign shared_out = shared_out_r;
  assign shared_oe = shared_oe_r;
  assign sdclk_out = sdclk_out_r;
  assign sdclk_oe = sdclk_oe_r;
  assign serial_result_out = sdo_r;
  assign busy = busy_r;
  assign cfg_range = cfg_range_r;
  assign cfg_mode = cfg_mode_r;
  assign irq = irq_r;

endmodule // adcsp_top

// ---- src/adcsp_map.svh ----
/*
  Constants for the converter shared-pin serial functions block.
  Assumes inclusion by the design top and the bench top.
*/
// Function
// - In parallel mode the five shared pins carry result bits eight to twelve, one pin per bit.
// - In serial master mode with frame polarity low the frame strobe is high while data is valid.
// - In serial master mode with frame polarity high the frame strobe is low while data is valid.
// - In serial slave mode the second shared pin is the incomplete-read flag.
// - A slave read still open when a conversion completes drops that result and pulses the flag.
// - In serial mode with source select low, range and mode come from the serial config port.
// - In serial mode with source select high, hardware pins give the config, the port is ignored.
// - Config bits arrive most significant first and are taken on a config clock edge.
// - The config clock edge used is chosen by the clock edge invert select.
// - Config clocks count only while the config port select is active.
// - Busy rises at conversion start and falls when the conversion ends, whether or not the result is latched.
`ifndef ADCSP_MAP_SVH
`define ADCSP_MAP_SVH

`define ADCSP_ADDR_CTRL 8'h00
`define ADCSP_ADDR_STATUS 8'h04
`define ADCSP_ADDR_IRQ_EN 8'h08
`define ADCSP_ADDR_IRQ_CLR 8'h0C
`define ADCSP_ADDR_RESULT 8'h10
`define ADCSP_ADDR_CONFIG 8'h14

`define ADCSP_CTRL_START 0
`define ADCSP_ST_DONE 0
`define ADCSP_ST_RDERR 1
`define ADCSP_ST_CFG 2
`define ADCSP_ST_W 3

`define ADCSP_RES_W 14
`define ADCSP_CFG_BITS 8
`define ADCSP_CFG_RANGE_LSB 0
`define ADCSP_CFG_MODE_LSB 2

`define ADCSP_CLK_MHZ 125
`define ADCSP_CONV_NS 800
`define ADCSP_CONV_CYC ((`ADCSP_CONV_NS * `ADCSP_CLK_MHZ + 999) / 1000)
`define ADCSP_SCLK_HALF 4

`endif

// ---- src/adcsp_pkg.sv ----
/*
  Types for the converter shared-pin serial functions block.
  Assumes the constants header sits beside it.
*/
package adcsp_pkg;
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_MREAD,
    SER_SREAD
  } adcsp_ser_t;
endpackage

// ---- testbench/adcsp_asserts.sv ----
/*
  Port checker for the shared-pin block.
  Assumes a bind onto adcsp_top from the bench top.
*/
`timescale 1ns/1ps
module adcsp_asserts (
  // Watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [4:0] shared_in,
  input wire logic [4:0] shared_out,
  input wire logic [4:0] shared_oe,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic frame_polarity_select,
  input wire logic [1:0] hw_range,
  input wire logic [1:0] hw_mode,
  input wire logic sdclk_out,
  input wire logic sdclk_oe,
  input wire logic serial_result_out,
  input wire logic busy,
  input wire logic [1:0] cfg_range,
  input wire logic [1:0] cfg_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic ser = serial_parallel_select;
  wire logic slv = clock_source_select;
  par_pins_a: assert property ((!ser)[*4] |-> shared_oe == 5'h1F && !sdclk_oe &&
    !serial_result_out) else $error("parallel pins wrong");
  master_pins_a: assert property ((ser && !slv)[*4] |-> shared_oe == 5'h01 &&
    sdclk_oe) else $error("master pins wrong");
  slave_pins_a: assert property ((ser && slv)[*4] |-> shared_oe == 5'h02 &&
    !sdclk_oe) else $error("slave pins wrong");
  busy_start_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0] &&
    !busy |=> busy) else $error("busy did not rise");
  busy_hold_a: assert property ($rose(busy) |-> (busy throughout ##96 1'b1) ##[1:10]
    !busy) else $error("busy length wrong");
  frame_pol_a: assert property (sdclk_oe && $rose(sdclk_out) |->
    shared_out[0] != frame_polarity_select) else $error("frame strobe wrong");
  rderr_pulse_a: assert property ($rose(shared_out[1]) && shared_oe == 5'h02 |=>
    !shared_out[1]) else $error("read error pulse too long");
  cfg_hw_a: assert property (($stable(hw_range) && $stable(hw_mode) &&
    (!ser || shared_in[2]))[*5] |-> cfg_range == hw_range && cfg_mode == hw_mode)
    else $error("hardware config not used");
  cover property ($fell(busy));
  cover property (sdclk_oe && $rose(sdclk_out));
  cover property (shared_oe == 5'h02 && shared_out[1]);
endmodule // adcsp_asserts

// ---- testbench/adcsp_host.sv ----
/*
  Host model: config port writes and slave read clock.
  Assumes the bench merges its pins with the block's enables.
*/
`timescale 1ns/1ps
module adcsp_host (
  // Host drive
  output logic [4:0] pins,
  output logic config_port_select_n,
  output logic sclk
);
  initial begin
    pins = 5'h00;
    config_port_select_n = 1'b1;
    sclk = 1'b0;
  end
  // Data flips after the active edge, so a wrong edge reads inverted bits
  task automatic cfg(input logic [7:0] w, input logic inv, input logic hw, input logic sel);
    #3 pins[2] = hw;
    pins[4] = inv;
    #40 config_port_select_n = !sel;
    for (int i = 7; i >= 0; i--) begin
      #40 pins[3] = w[i];
      #40 pins[4] = !inv;
      #40 pins[3] = !w[i];
      #40 pins[4] = inv;
    end
    // Closing select pulse: clocks seen while deselected would load here
    #40 config_port_select_n = 1'b0;
    #40 config_port_select_n = 1'b1;
  endtask
  // Clock stands at idle level between frames
  task automatic slave(input int n, input logic inv);
    #3 sclk = inv;
    repeat (n) begin
      #80 sclk = !inv;
      #80 sclk = inv;
    end
  endtask
endmodule // adcsp_host

// ---- testbench/tb_top.sv ----
/*
  Bench top: clock, reset, host model, scenarios and verdict.
  Assumes design, checker and host model are compiled first.
*/
`timescale 1ns/1ps
`include "adcsp_map.svh"
module tb_top;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic serial_parallel_select = 1'b0, clock_source_select = 1'b0;
  logic frame_polarity_select = 1'b0, clock_edge_invert = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v;
  logic [13:0] conv_data = 14'h2A5C;
  logic [1:0] hw_range = 2'h1, hw_mode = 2'h2, cfg_range, cfg_mode;
  logic [4:0] shared_out, shared_oe, hp;
  logic busy, irq, sdclk_out, sdclk_oe, serial_result_out, cs_n, sclk;
  logic conv_start_n = 1'b1;
  wire logic [4:0] shared_in = (shared_oe & shared_out) | (~shared_oe & hp);
  int bad_count = 0, n_compared = 0;
  initial forever #4 clk = ~clk;
  adcsp_host host (.pins(hp), .config_port_select_n(cs_n), .sclk);
  adcsp_top dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shared_in, .shared_out, .shared_oe, .serial_parallel_select, .clock_source_select,
    .frame_polarity_select, .clock_edge_invert, .config_port_select_n(cs_n), .hw_range,
    .hw_mode, .sdclk_in(sdclk_oe ? sdclk_out : sclk), .sdclk_out, .sdclk_oe,
    .serial_result_out, .conv_start_n, .conv_data, .busy, .cfg_range, .cfg_mode, .irq);
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic conv(input logic pin);
    if (pin) begin
      @(posedge clk);
      conv_start_n <= 1'b0;
      repeat (4) @(posedge clk);
      conv_start_n <= 1'b1;
      cyc(1);
    end else begin
      wr(`ADCSP_ADDR_CTRL, 32'h0000_0001);
      cyc(2);
    end
    chk("busy high", busy, 1'b1);
    for (int i = 0; i < 200 && busy; i++) cyc(1);
    chk("busy", busy, 1'b0);
  endtask
  task automatic t_par();
    conv(1'b1);
    cyc(3);
    chk("pins", shared_out, 5'h0A);
    chk("oe", shared_oe, 5'h1F);
    chk("irq masked", irq, 1'b0);
    wr(`ADCSP_ADDR_RESULT, 32'h0000_0000);
    rd(`ADCSP_ADDR_RESULT);
    chk("result", v, 32'h0000_2A5C);
    rd(8'h20);
    chk("unmapped", v, 32'h0000_0000);
    wr(`ADCSP_ADDR_IRQ_EN, 32'h0000_0001);
    cyc(2);
    chk("irq set", irq, 1'b1);
    wr(`ADCSP_ADDR_IRQ_CLR, 32'h0000_0001);
    cyc(2);
    chk("irq clear", irq, 1'b0);
    $display("test parallel done");
  endtask
  task automatic t_master(input logic pol);
    logic [13:0] w;
    logic p;
    @(posedge clk);
    serial_parallel_select <= 1'b1;
    frame_polarity_select <= pol;
    conv_data <= {pol, 13'h0A5B};
    cyc(6);
    wr(`ADCSP_ADDR_CTRL, 32'h0000_0001);
    p = sdclk_out;
    for (int k = 13; k >= 0; k--) begin
      for (int g = 0; g < 300 && !(!p && sdclk_out); g++) begin
        p = sdclk_out;
        cyc(1);
      end
      w[k] = serial_result_out;
      chk("frame", shared_out[0], !pol);
      p = sdclk_out;
    end
    chk("serial word", w, {pol, 13'h0A5B});
    cyc(20);
    chk("frame idle", shared_out[0], pol);
    $display("test master done");
  endtask
  task automatic t_cfg(input logic inv, input logic [7:0] w);
    @(posedge clk);
    clock_edge_invert <= inv;
    cyc(5);
    host.cfg(w, inv, 1'b0, 1'b1);
    cyc(8);
    chk("range", cfg_range, w[1:0]);
    chk("mode", cfg_mode, w[3:2]);
    rd(`ADCSP_ADDR_CONFIG);
    chk("word", v[11:4], w);
    host.cfg(~w, inv, 1'b0, 1'b0);
    cyc(8);
    chk("deselected", cfg_range, w[1:0]);
    $display("test config done");
  endtask
  task automatic t_hw();
    host.cfg(8'hFF, 1'b0, 1'b1, 1'b1);
    cyc(8);
    chk("hw range", cfg_range, hw_range);
    chk("hw mode", cfg_mode, hw_mode);
    rd(`ADCSP_ADDR_CONFIG);
    chk("hw port ignored", v[11:4], 8'h47);
    $display("test hardware config done");
  endtask
  task automatic t_slave();
    int n;
    @(posedge clk);
    clock_source_select <= 1'b1;
    conv_data <= 14'h0F0F;
    cyc(6);
    chk("slave oe", shared_oe, 5'h02);
    conv(1'b0);
    host.slave(5, 1'b1);
    @(posedge clk);
    conv_data <= 14'h3333;
    wr(`ADCSP_ADDR_CTRL, 32'h0000_0001);
    n = 0;
    repeat (250) begin
      cyc(1);
      n += shared_out[1];
    end
    chk("pulses", n, 1);
    rd(`ADCSP_ADDR_RESULT);
    chk("kept", v, 32'h0000_0F0F);
    $display("test slave done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(3);
    t_par();
    t_master(1'b0);
    t_master(1'b1);
    t_cfg(1'b0, 8'hB6);
    t_cfg(1'b1, 8'h47);
    t_hw();
    t_slave();
    print_verdict();
  end
  initial begin
    #200_000;
    bad_count++;
    print_verdict();
  end
endmodule // tb_top
bind adcsp_top adcsp_asserts chk_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .shared_in, .shared_out, .shared_oe, .serial_parallel_select, .clock_source_select,
  .frame_polarity_select, .hw_range, .hw_mode, .sdclk_out, .sdclk_oe, .serial_result_out,
  .busy, .cfg_range, .cfg_mode);
